// >>> include/smsq_params.svh
// Offsets, field positions, reset values and counts of the supply sequencer
`ifndef SMSQ_PARAMS_SVH
`define SMSQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define SMSQ_NCH           8
`define SMSQ_TW            16
`define SMSQ_NEV           5

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SMSQ_OFF_CTRL      8'h00
`define SMSQ_OFF_UV_IEN    8'h04
`define SMSQ_OFF_OV_IEN    8'h08
`define SMSQ_OFF_AUTO_ON   8'h0c
`define SMSQ_OFF_AUTO_SLP  8'h10
`define SMSQ_OFF_AUTO_OFF  8'h14
`define SMSQ_OFF_SEQ_TIME  8'h18
`define SMSQ_OFF_STATUS    8'h1c
`define SMSQ_OFF_UV_FLAG   8'h20
`define SMSQ_OFF_OV_FLAG   8'h24
`define SMSQ_OFF_EVT_STAT  8'h28
`define SMSQ_OFF_EVT_MASK  8'h2c
`define SMSQ_OFF_MASK_STAT 8'h30

// ----------------------------------------------------------------------------
// Event bit positions
// ----------------------------------------------------------------------------
`define SMSQ_EV_SEQ_START  0
`define SMSQ_EV_SEQ_DONE   1
`define SMSQ_EV_BIST_DONE  2
`define SMSQ_EV_BIST_FAIL  3
`define SMSQ_EV_FAULT      4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SMSQ_RST_TOUT      16'h0100
`define SMSQ_RST_IEN       8'hff
`define SMSQ_RST_AUTO      8'h00
`define SMSQ_RST_EVT_MASK  5'h00

`endif

// >>> include/smsq_pkg.sv
// Types shared by the supply sequencer modules
`include "smsq_params.svh"

package smsq_pkg;

	typedef enum logic [2:0] {
		SMSQ_IDLE     = 3'h0,
		SMSQ_SEQ1     = 3'h1,
		SMSQ_ACTIVE   = 3'h3,
		SMSQ_SEQ2     = 3'h2,
		SMSQ_BIST     = 3'h6,
		SMSQ_FAILSAFE = 3'h7
	} smsq_state_t;

	typedef enum logic [1:0] {
		SMSQ_KIND_ON   = 2'h0,
		SMSQ_KIND_ENS  = 2'h1,
		SMSQ_KIND_EXIT = 2'h3
	} smsq_kind_t;

	typedef enum logic [2:0] {
		SMSQ_OP_NOP      = 3'h0,
		SMSQ_OP_LOAD     = 3'h1,
		SMSQ_OP_LOAD_ARM = 3'h2,
		SMSQ_OP_ARM      = 3'h3,
		SMSQ_OP_CLEAR    = 3'h4,
		SMSQ_OP_UV_ALL   = 3'h5
	} smsq_op_t;

	typedef struct packed {
		logic uv_m;
		logic uv_s;
		logic ov_m;
		logic ov_s;
		logic bo_m;
		logic bo_s;
		logic uv_mask;
		logic ov_mask;
		logic arm;
		logic uv_flag;
		logic ov_flag;
	} smsq_chan_st_t;

	typedef struct packed {
		smsq_state_t            state;
		smsq_kind_t             kind;
		logic                   act_m;
		logic                   act_s;
		logic                   act_d;
		logic                   slp_m;
		logic                   slp_s;
		logic                   slp_d;
		logic                   pin_m;
		logic                   pin_s;
		logic                   on_done;
		logic                   fault_d;
		logic [`SMSQ_TW-1:0]    cnt;
		logic [`SMSQ_TW-1:0]    tout;
		logic [`SMSQ_NCH-1:0]   uv_ien;
		logic [`SMSQ_NCH-1:0]   ov_ien;
		logic [`SMSQ_NCH-1:0]   auto_on;
		logic [`SMSQ_NCH-1:0]   auto_slp;
		logic [`SMSQ_NCH-1:0]   auto_off;
		logic                   at_shdn;
		logic [`SMSQ_NEV-1:0]   evt;
		logic [`SMSQ_NEV-1:0]   evt_mask;
		logic [31:0]            prdata;
		logic                   st_start;
		smsq_op_t               op;
		logic [`SMSQ_NCH-1:0]   ld_uv;
		logic [`SMSQ_NCH-1:0]   ld_ov;
	} smsq_top_st_t;

endpackage

// >>> include/smsq_ch_if.sv
// Carrier between the sequencer core and one channel mask/flag slice
interface smsq_ch_if;
	logic               uv_raw;
	logic               ov_raw;
	logic               below_off;
	logic               uv_ien;
	logic               ov_ien;
	logic               chk_uv;
	logic               chk_ov;
	logic               uv_w1c;
	logic               ov_w1c;
	smsq_pkg::smsq_op_t op;
	logic               ld_uv;
	logic               ld_ov;
	logic               uv_flag;
	logic               ov_flag;
	logic               uv_masked;
	logic               ov_masked;

	modport ctl (
		output uv_raw, ov_raw, below_off, uv_ien, ov_ien, chk_uv, chk_ov,
		output uv_w1c, ov_w1c, op, ld_uv, ld_ov,
		input  uv_flag, ov_flag, uv_masked, ov_masked
	);
	modport chan (
		input  uv_raw, ov_raw, below_off, uv_ien, ov_ien, chk_uv, chk_ov,
		input  uv_w1c, ov_w1c, op, ld_uv, ld_ov,
		output uv_flag, ov_flag, uv_masked, ov_masked
	);
endinterface

// >>> rtl/smsq_chan.sv
// One channel: comparator synchronisers, auto-mask bits and latched fault flags
module smsq_chan (
	input wire logic   pclk,
	input wire logic   presetn,
	smsq_ch_if.chan    ch
);

	smsq_pkg::smsq_chan_st_t r;
	smsq_pkg::smsq_chan_st_t n;

	always_comb begin
		n = r;
		n.uv_m = ch.uv_raw;
		n.uv_s = r.uv_m;
		n.ov_m = ch.ov_raw;
		n.ov_s = r.ov_m;
		n.bo_m = ch.below_off;
		n.bo_s = r.bo_m;
		// Rail has passed its off threshold: hand over to the enables
		if (r.arm && !r.bo_s) begin
			n.uv_mask = 1'b0;
			n.ov_mask = 1'b0;
			n.arm     = 1'b0;
		end
		// A new sequence replaces whatever was pending
		case (ch.op)
			smsq_pkg::SMSQ_OP_LOAD: begin
				n.uv_mask = ch.ld_uv;
				n.ov_mask = ch.ld_ov;
				n.arm     = 1'b0;
			end
			smsq_pkg::SMSQ_OP_LOAD_ARM: begin
				n.uv_mask = ch.ld_uv;
				n.ov_mask = ch.ld_ov;
				n.arm     = 1'b1;
			end
			smsq_pkg::SMSQ_OP_ARM: begin
				n.arm = 1'b1;
			end
			smsq_pkg::SMSQ_OP_CLEAR: begin
				n.uv_mask = 1'b0;
				n.ov_mask = 1'b0;
				n.arm     = 1'b0;
			end
			smsq_pkg::SMSQ_OP_UV_ALL: begin
				n.uv_mask = 1'b1;
				n.arm     = 1'b0;
			end
			default: begin
			end
		endcase
		// Set wins over clear; clear only once the fault is gone
		n.uv_flag = (r.uv_s && ch.chk_uv && ch.uv_ien && !r.uv_mask)
			|| (r.uv_flag && !(ch.uv_w1c && !r.uv_s));
		n.ov_flag = (r.ov_s && ch.chk_ov && ch.ov_ien && !r.ov_mask)
			|| (r.ov_flag && !(ch.ov_w1c && !r.ov_s));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ch.uv_flag   = r.uv_flag;
	assign ch.ov_flag   = r.ov_flag;
	assign ch.uv_masked = r.uv_mask;
	assign ch.ov_masked = r.ov_mask;

endmodule

// >>> rtl/smsq_top.sv
// Mode and sequencing controller of a multichannel window supply supervisor
`include "smsq_params.svh"

module smsq_top (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                activation_input,
	input  wire logic                sleep_req_n,
	input  wire logic [`SMSQ_NCH-1:0] undervoltage_fast,
	input  wire logic [`SMSQ_NCH-1:0] overvoltage_fast,
	input  wire logic [`SMSQ_NCH-1:0] sense_below_off,
	input  wire logic                selftest_done,
	input  wire logic                selftest_pass,
	output logic                     selftest_start,
	input  wire logic                fault_interrupt_n_in,
	output logic                     fault_interrupt_n_out,
	output logic                     fault_interrupt_n_oe,
	output logic                     irq
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	smsq_pkg::smsq_top_st_t r;
	smsq_pkg::smsq_top_st_t n;

	logic [`SMSQ_NCH-1:0]  uv_flags;
	logic [`SMSQ_NCH-1:0]  ov_flags;
	logic [`SMSQ_NCH-1:0]  uv_masked;
	logic [`SMSQ_NCH-1:0]  ov_masked;
	logic [`SMSQ_NCH-1:0]  uv_w1c;
	logic [`SMSQ_NCH-1:0]  ov_w1c;
	logic                  chk_uv;
	logic                  chk_ov;
	logic                  fault_any;
	logic                  act_rise;
	logic                  act_fall;
	logic                  slp_rise;
	logic                  slp_fall;
	logic                  timeout;
	logic                  wr_en;
	logic                  addr_hit;
	logic [31:0]           rd_data;
	logic [`SMSQ_NEV-1:0]  ev;

	// ------------------------------------------------------------------------
	// Channel slices
	// ------------------------------------------------------------------------
	smsq_ch_if ch [`SMSQ_NCH] ();

	genvar gi;
	generate
		for (gi = 0; gi < `SMSQ_NCH; gi = gi + 1) begin : g_ch
			assign ch[gi].uv_raw    = undervoltage_fast[gi];
			assign ch[gi].ov_raw    = overvoltage_fast[gi];
			assign ch[gi].below_off = sense_below_off[gi];
			assign ch[gi].uv_ien    = r.uv_ien[gi];
			assign ch[gi].ov_ien    = r.ov_ien[gi];
			assign ch[gi].chk_uv    = chk_uv;
			assign ch[gi].chk_ov    = chk_ov;
			assign ch[gi].uv_w1c    = uv_w1c[gi];
			assign ch[gi].ov_w1c    = ov_w1c[gi];
			assign ch[gi].op        = r.op;
			assign ch[gi].ld_uv     = r.ld_uv[gi];
			assign ch[gi].ld_ov     = r.ld_ov[gi];
			assign uv_flags[gi]     = ch[gi].uv_flag;
			assign ov_flags[gi]     = ch[gi].ov_flag;
			assign uv_masked[gi]    = ch[gi].uv_masked;
			assign ov_masked[gi]    = ch[gi].ov_masked;

			smsq_chan u_chan (
				.pclk    (pclk),
				.presetn (presetn),
				.ch      (ch[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------------
	// Sequences keep monitoring; the masks and the uv_ien/ov_ien enables shape what reports
	assign chk_uv = (r.state == smsq_pkg::SMSQ_SEQ1)
		|| (r.state == smsq_pkg::SMSQ_ACTIVE)
		|| (r.state == smsq_pkg::SMSQ_SEQ2);
	assign chk_ov = chk_uv || (r.state == smsq_pkg::SMSQ_IDLE);

	assign act_rise = r.act_s && !r.act_d;
	assign act_fall = !r.act_s && r.act_d;
	assign slp_rise = r.slp_s && !r.slp_d;
	assign slp_fall = !r.slp_s && r.slp_d;
	assign timeout  = (r.cnt >= r.tout);

	assign fault_any = (|uv_flags) || (|ov_flags);

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	assign wr_en  = psel && penable && pwrite;
	assign uv_w1c = (wr_en && paddr == `SMSQ_OFF_UV_FLAG) ? pwdata[`SMSQ_NCH-1:0] : '0;
	assign ov_w1c = (wr_en && paddr == `SMSQ_OFF_OV_FLAG) ? pwdata[`SMSQ_NCH-1:0] : '0;

	always_comb begin
		addr_hit = 1'b1;
		rd_data  = 32'h0000_0000;
		case (paddr)
			`SMSQ_OFF_CTRL:      rd_data[0] = r.at_shdn;
			`SMSQ_OFF_UV_IEN:    rd_data[`SMSQ_NCH-1:0] = r.uv_ien;
			`SMSQ_OFF_OV_IEN:    rd_data[`SMSQ_NCH-1:0] = r.ov_ien;
			`SMSQ_OFF_AUTO_ON:   rd_data[`SMSQ_NCH-1:0] = r.auto_on;
			`SMSQ_OFF_AUTO_SLP:  rd_data[`SMSQ_NCH-1:0] = r.auto_slp;
			`SMSQ_OFF_AUTO_OFF:  rd_data[`SMSQ_NCH-1:0] = r.auto_off;
			`SMSQ_OFF_SEQ_TIME:  rd_data[`SMSQ_TW-1:0] = r.tout;
			`SMSQ_OFF_STATUS: begin
				rd_data[2:0] = r.state;
				rd_data[4:3] = r.kind;
				rd_data[5]   = r.act_s;
				rd_data[6]   = r.slp_s;
				rd_data[7]   = r.on_done;
				rd_data[8]   = r.pin_s;
				rd_data[9]   = fault_any;
			end
			`SMSQ_OFF_UV_FLAG:   rd_data[`SMSQ_NCH-1:0] = uv_flags;
			`SMSQ_OFF_OV_FLAG:   rd_data[`SMSQ_NCH-1:0] = ov_flags;
			`SMSQ_OFF_EVT_STAT:  rd_data[`SMSQ_NEV-1:0] = r.evt;
			`SMSQ_OFF_EVT_MASK:  rd_data[`SMSQ_NEV-1:0] = r.evt_mask;
			`SMSQ_OFF_MASK_STAT: rd_data[2*`SMSQ_NCH-1:0] = {ov_masked, uv_masked};
			default:             addr_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		n  = r;
		ev = '0;

		// Pins cross into pclk through two flops each
		n.act_m = activation_input;
		n.act_s = r.act_m;
		n.act_d = r.act_s;
		n.slp_m = sleep_req_n;
		n.slp_s = r.slp_m;
		n.slp_d = r.slp_s;
		n.pin_m = fault_interrupt_n_in;
		n.pin_s = r.pin_m;

		n.op       = smsq_pkg::SMSQ_OP_NOP;
		n.st_start = 1'b0;
		n.fault_d  = fault_any;

		if (r.state == smsq_pkg::SMSQ_SEQ1 || r.state == smsq_pkg::SMSQ_SEQ2) begin
			n.cnt = r.cnt + `SMSQ_TW'(1);
		end else begin
			n.cnt = '0;
		end

		case (r.state)
			smsq_pkg::SMSQ_IDLE, smsq_pkg::SMSQ_SEQ2: begin
				if (act_rise) begin
					n.state   = smsq_pkg::SMSQ_SEQ1;
					n.kind    = smsq_pkg::SMSQ_KIND_ON;
					n.cnt     = '0;
					n.on_done = 1'b0;
					n.op      = smsq_pkg::SMSQ_OP_LOAD_ARM;
					n.ld_uv   = r.auto_on;
					n.ld_ov   = '0;
					ev[`SMSQ_EV_SEQ_START] = 1'b1;
				end else if (r.state == smsq_pkg::SMSQ_SEQ2 && timeout) begin
					n.op = smsq_pkg::SMSQ_OP_UV_ALL;
					ev[`SMSQ_EV_SEQ_DONE] = 1'b1;
					if (r.at_shdn) begin
						n.state    = smsq_pkg::SMSQ_BIST;
						n.st_start = 1'b1;
					end else begin
						n.state = smsq_pkg::SMSQ_IDLE;
					end
				end
			end
			smsq_pkg::SMSQ_SEQ1, smsq_pkg::SMSQ_ACTIVE: begin
				if (act_fall) begin
					n.state   = smsq_pkg::SMSQ_SEQ2;
					n.cnt     = '0;
					n.on_done = 1'b0;
					n.op      = smsq_pkg::SMSQ_OP_LOAD;
					n.ld_uv   = r.auto_off;
					n.ld_ov   = '0;
					ev[`SMSQ_EV_SEQ_START] = 1'b1;
				end else if (r.act_s && r.on_done && slp_fall) begin
					n.state = smsq_pkg::SMSQ_SEQ1;
					n.kind  = smsq_pkg::SMSQ_KIND_ENS;
					n.cnt   = '0;
					n.op    = smsq_pkg::SMSQ_OP_LOAD;
					n.ld_uv = r.auto_slp;
					n.ld_ov = r.auto_slp;
					ev[`SMSQ_EV_SEQ_START] = 1'b1;
				end else if (r.act_s && r.on_done && slp_rise) begin
					n.state = smsq_pkg::SMSQ_SEQ1;
					n.kind  = smsq_pkg::SMSQ_KIND_EXIT;
					n.cnt   = '0;
					n.op    = smsq_pkg::SMSQ_OP_ARM;
					ev[`SMSQ_EV_SEQ_START] = 1'b1;
				end else if (r.state == smsq_pkg::SMSQ_SEQ1 && timeout) begin
					n.state = smsq_pkg::SMSQ_ACTIVE;
					ev[`SMSQ_EV_SEQ_DONE] = 1'b1;
					case (r.kind)
						smsq_pkg::SMSQ_KIND_ON: begin
							n.op      = smsq_pkg::SMSQ_OP_CLEAR;
							n.on_done = 1'b1;
						end
						smsq_pkg::SMSQ_KIND_EXIT: begin
							n.op = smsq_pkg::SMSQ_OP_CLEAR;
						end
						default: begin
							// Sleep masks stay until the next edge
							n.op = smsq_pkg::SMSQ_OP_NOP;
						end
					endcase
				end
			end
			smsq_pkg::SMSQ_BIST: begin
				// Pins are ignored until the self-test reports
				if (selftest_done) begin
					ev[`SMSQ_EV_BIST_DONE] = 1'b1;
					if (selftest_pass) begin
						n.state = smsq_pkg::SMSQ_IDLE;
					end else begin
						n.state = smsq_pkg::SMSQ_FAILSAFE;
						ev[`SMSQ_EV_BIST_FAIL] = 1'b1;
					end
				end
			end
			smsq_pkg::SMSQ_FAILSAFE: begin
				// Left only through reset
				n.state = smsq_pkg::SMSQ_FAILSAFE;
			end
			default: begin
				n.state = smsq_pkg::SMSQ_IDLE;
			end
		endcase

		ev[`SMSQ_EV_FAULT] = fault_any && !r.fault_d;

		// Register writes take effect in the access phase
		if (wr_en) begin
			case (paddr)
				`SMSQ_OFF_CTRL:     n.at_shdn  = pwdata[0];
				`SMSQ_OFF_UV_IEN:   n.uv_ien   = pwdata[`SMSQ_NCH-1:0];
				`SMSQ_OFF_OV_IEN:   n.ov_ien   = pwdata[`SMSQ_NCH-1:0];
				`SMSQ_OFF_AUTO_ON:  n.auto_on  = pwdata[`SMSQ_NCH-1:0];
				`SMSQ_OFF_AUTO_SLP: n.auto_slp = pwdata[`SMSQ_NCH-1:0];
				`SMSQ_OFF_AUTO_OFF: n.auto_off = pwdata[`SMSQ_NCH-1:0];
				`SMSQ_OFF_SEQ_TIME: n.tout     = pwdata[`SMSQ_TW-1:0];
				`SMSQ_OFF_EVT_MASK: n.evt_mask = pwdata[`SMSQ_NEV-1:0];
				default: begin
				end
			endcase
		end

		// Sticky events; a new event beats a same-cycle clear
		if (wr_en && paddr == `SMSQ_OFF_EVT_STAT) begin
			n.evt = (r.evt & ~pwdata[`SMSQ_NEV-1:0]) | ev;
		end else begin
			n.evt = r.evt | ev;
		end

		// Read data captured in the setup phase, shown in the access phase
		if (psel && !penable) begin
			n.prdata = rd_data;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r          <= '0;
			r.state    <= smsq_pkg::SMSQ_IDLE;
			r.kind     <= smsq_pkg::SMSQ_KIND_ON;
			r.op       <= smsq_pkg::SMSQ_OP_NOP;
			r.tout     <= `SMSQ_RST_TOUT;
			r.uv_ien   <= `SMSQ_RST_IEN;
			r.ov_ien   <= `SMSQ_RST_IEN;
			r.auto_on  <= `SMSQ_RST_AUTO;
			r.auto_slp <= `SMSQ_RST_AUTO;
			r.auto_off <= `SMSQ_RST_AUTO;
			// Sleep pin idles high; a low reset value would fake an edge
			r.slp_m    <= 1'b1;
			r.slp_s    <= 1'b1;
			r.slp_d    <= 1'b1;
			r.evt_mask <= `SMSQ_RST_EVT_MASK;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign prdata                = r.prdata;
	assign pready                = psel && penable;
	assign pslverr               = psel && penable && !addr_hit;
	assign selftest_start        = r.st_start;
	// Open drain: only ever pulls low, held while any flag is latched
	assign fault_interrupt_n_out = 1'b0;
	assign fault_interrupt_n_oe  = fault_any;
	assign irq                   = |(r.evt & r.evt_mask);

endmodule

// >>> verif/smsq_top_sva.sv
// Port-level assertions of the supply sequencer
`include "smsq_params.svh"

module smsq_top_sva (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 activation_input,
	input wire logic [`SMSQ_NCH-1:0] undervoltage_fast,
	input wire logic [`SMSQ_NCH-1:0] overvoltage_fast,
	input wire logic                 selftest_start,
	input wire logic                 fault_interrupt_n_out,
	input wire logic                 fault_interrupt_n_oe,
	input wire logic                 irq
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0] msk_r;
	logic       shdn_r;
	wire        any_flt = |(undervoltage_fast | overvoltage_fast);
	wire        wr_go   = psel && penable && pwrite;
	wire        flag_wr = wr_go && (paddr == `SMSQ_OFF_UV_FLAG || paddr == `SMSQ_OFF_OV_FLAG);

	// Shadows of event mask and shutdown test bit, so gating can be judged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msk_r  <= 5'h00;
			shdn_r <= 1'b0;
		end else begin
			if (wr_go && paddr == `SMSQ_OFF_EVT_MASK) begin
				msk_r <= pwdata[4:0];
			end
			if (wr_go && paddr == `SMSQ_OFF_CTRL) begin
				shdn_r <= pwdata[0];
			end
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence act_rise_s;
		$rose(activation_input) ##0 msk_r[0];
	endsequence
	sequence irq_soon_s;
		##[2:6] irq;
	endsequence
	sequence bist_pulse_s;
		selftest_start ##1 !selftest_start;
	endsequence

	ready_comb_a: assert property (pready == (psel && penable))
		else $error("pready not following psel and penable");
	bad_addr_a: assert property (psel && penable && paddr > `SMSQ_OFF_MASK_STAT |-> pslverr)
		else $error("no slave error on unmapped address");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");
	pin_low_a: assert property (fault_interrupt_n_out == 1'b0)
		else $error("fault pin driven high");
	irq_latch_a: assert property (fault_interrupt_n_oe && !flag_wr |=> fault_interrupt_n_oe)
		else $error("fault pin released without flag clear");
	irq_cause_a: assert property ($rose(fault_interrupt_n_oe) |-> $past(any_flt, 3))
		else $error("fault pin asserted without comparator fault");
	seq_event_a: assert property (act_rise_s |-> irq_soon_s)
		else $error("no sequence start event after activation rise");
	bist_gate_a: assert property (selftest_start |-> shdn_r)
		else $error("self-test started while disabled");
	bist_pulse_a: assert property (selftest_start |-> bist_pulse_s)
		else $error("self-test start longer than one cycle");
	irq_masked_a: assert property (msk_r == 5'h00 && $past(msk_r) == 5'h00 |-> !irq)
		else $error("interrupt high with all events masked");
endmodule

bind smsq_top smsq_top_sva u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.activation_input(activation_input), .undervoltage_fast(undervoltage_fast),
	.overvoltage_fast(overvoltage_fast), .selftest_start(selftest_start),
	.fault_interrupt_n_out(fault_interrupt_n_out),
	.fault_interrupt_n_oe(fault_interrupt_n_oe), .irq(irq)
);

// >>> verif/smsq_host_model.sv
// Host-side driver of the activation and sleep request pins
module smsq_host_model (
	input  wire logic pclk,
	output logic      activation_input,
	output logic      sleep_req_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		activation_input = 1'b0;
		sleep_req_n      = 1'b1;
	end

	// Pins are held levels; a sequencer never floats them
	task automatic drive(input logic act, input logic slp_n);
		@(posedge pclk);
		activation_input <= act;
		sleep_req_n      <= slp_n;
	endtask
endmodule

// >>> verif/smsq_top_tb.sv
// Self-checking bench of the supply sequencer
`include "smsq_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end

module smsq_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] TOUT = 16'h0040;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, uv, ov, below;
	logic [31:0] pwdata, prdata, rd;
	logic        act, slp_n, st_done, st_pass, st_start, fint_out, fint_oe, irq;
	int          n_mismatch, checks, cyc_n, n;
	wire         fint_pin = !fint_oe;

	smsq_top DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.activation_input(act), .sleep_req_n(slp_n), .undervoltage_fast(uv),
		.overvoltage_fast(ov), .sense_below_off(below), .selftest_done(st_done),
		.selftest_pass(st_pass), .selftest_start(st_start), .fault_interrupt_n_in(fint_pin),
		.fault_interrupt_n_out(fint_out), .fault_interrupt_n_oe(fint_oe), .irq(irq)
	);
	smsq_host_model host (.pclk(pclk), .activation_input(act), .sleep_req_n(slp_n));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	// --------------------------------------------------------------------
	// Bus and helper tasks
	// --------------------------------------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask

	// --------------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------------
	task automatic t_regs;
		rchk(`SMSQ_OFF_UV_IEN, 32'hffffffff, 32'h000000ff);
		rchk(`SMSQ_OFF_SEQ_TIME, 32'hffffffff, 32'h00000100);
		apb(1'b0, 8'h40, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b1, `SMSQ_OFF_STATUS, 32'h7);
		rchk(`SMSQ_OFF_STATUS, 32'h7, 32'h0);
		host.drive(1'b0, 1'b0);
		cyc(6);
		rchk(`SMSQ_OFF_EVT_STAT, 32'h1, 32'h0);
		host.drive(1'b0, 1'b1);
	endtask

	task automatic t_idle;
		uv <= 8'h01;
		ov <= 8'h02;
		cyc(8);
		rchk(`SMSQ_OFF_UV_FLAG, 32'hff, 32'h0);
		rchk(`SMSQ_OFF_OV_FLAG, 32'hff, 32'h2);
		apb(1'b1, `SMSQ_OFF_OV_FLAG, 32'h2);
		rchk(`SMSQ_OFF_OV_FLAG, 32'hff, 32'h2);
		uv <= 8'h00;
		ov <= 8'h00;
		cyc(4);
		@(negedge pclk);
		`CHK(fint_oe, 1'b1)
		rchk(`SMSQ_OFF_STATUS, 32'h100, 32'h0);
		apb(1'b1, `SMSQ_OFF_OV_FLAG, 32'h2);
		@(negedge pclk);
		`CHK(fint_oe, 1'b0)
	endtask

	task automatic t_power_on;
		apb(1'b1, `SMSQ_OFF_EVT_STAT, 32'h1f);
		apb(1'b1, `SMSQ_OFF_AUTO_ON, 32'h03);
		apb(1'b1, `SMSQ_OFF_EVT_MASK, 32'h01);
		below <= 8'h01;
		host.drive(1'b1, 1'b1);
		cyc(8);
		@(negedge pclk);
		`CHK(irq, 1'b1)
		rchk(`SMSQ_OFF_STATUS, 32'h1f, 32'h01);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0001);
		uv <= 8'h01;
		cyc(5);
		rchk(`SMSQ_OFF_UV_FLAG, 32'hff, 32'h0);
		uv <= 8'h00;
		below <= 8'h00;
		host.drive(1'b1, 1'b0);
		cyc(6);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0);
		rchk(`SMSQ_OFF_STATUS, 32'h18, 32'h0);
		host.drive(1'b1, 1'b1);
		cyc(TOUT);
		rchk(`SMSQ_OFF_STATUS, 32'hff, 32'he3);
		apb(1'b1, `SMSQ_OFF_EVT_MASK, 32'h00);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, `SMSQ_OFF_EVT_STAT, 32'h1f);
		apb(1'b1, `SMSQ_OFF_EVT_MASK, 32'h1f);
		@(negedge pclk);
		`CHK(irq, 1'b0)
	endtask

	task automatic t_active;
		apb(1'b1, `SMSQ_OFF_UV_IEN, 32'hf7);
		uv <= 8'h08;
		cyc(5);
		rchk(`SMSQ_OFF_UV_FLAG, 32'hff, 32'h0);
		apb(1'b1, `SMSQ_OFF_UV_IEN, 32'hff);
		cyc(5);
		rchk(`SMSQ_OFF_UV_FLAG, 32'hff, 32'h08);
		uv <= 8'h00;
		cyc(4);
		apb(1'b1, `SMSQ_OFF_UV_FLAG, 32'h08);
		@(negedge pclk);
		`CHK(fint_oe, 1'b0)
	endtask

	task automatic t_sleep;
		apb(1'b1, `SMSQ_OFF_AUTO_SLP, 32'h04);
		below <= 8'h04;
		host.drive(1'b1, 1'b0);
		cyc(TOUT + 8);
		rchk(`SMSQ_OFF_STATUS, 32'h1f, 32'h0b);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0404);
		uv <= 8'h04;
		ov <= 8'h04;
		cyc(5);
		rchk(`SMSQ_OFF_UV_FLAG, 32'hff, 32'h0);
		rchk(`SMSQ_OFF_OV_FLAG, 32'hff, 32'h0);
		uv <= 8'h00;
		ov <= 8'h00;
		host.drive(1'b1, 1'b1);
		cyc(10);
		rchk(`SMSQ_OFF_STATUS, 32'h1f, 32'h19);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0404);
		below <= 8'h00;
		cyc(6);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0);
		cyc(TOUT);
		rchk(`SMSQ_OFF_STATUS, 32'h1f, 32'h1b);
	endtask

	task automatic t_restart;
		host.drive(1'b1, 1'b0);
		cyc(40);
		host.drive(1'b1, 1'b1);
		cyc(40);
		rchk(`SMSQ_OFF_STATUS, 32'h1f, 32'h19);
		cyc(TOUT);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0);
	endtask

	task automatic t_power_off(input logic shdn, input logic pass);
		apb(1'b1, `SMSQ_OFF_AUTO_OFF, 32'h10);
		apb(1'b1, `SMSQ_OFF_CTRL, {31'h0, shdn});
		host.drive(1'b0, 1'b1);
		cyc(8);
		rchk(`SMSQ_OFF_STATUS, 32'h7, 32'h2);
		rchk(`SMSQ_OFF_MASK_STAT, 32'hffff, 32'h0010);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (st_start !== 1'b1 && n < 200);
		`CHK(st_start, shdn)
		rchk(`SMSQ_OFF_MASK_STAT, 32'hff, 32'hff);
		if (shdn) begin
			st_pass <= pass;
			st_done <= 1'b1;
			@(posedge pclk);
			st_done <= 1'b0;
			cyc(3);
		end
		rchk(`SMSQ_OFF_STATUS, 32'h7, (shdn && !pass) ? 32'h7 : 32'h0);
		rchk(`SMSQ_OFF_EVT_STAT, 32'hc, {28'h0, shdn && !pass, shdn, 2'h0});
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{uv, ov, st_done, st_pass, n_mismatch, checks, cyc_n} = '0;
		below = 8'hff;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		cyc(4);
		t_regs();
		apb(1'b1, `SMSQ_OFF_SEQ_TIME, {16'h0, TOUT});
		t_idle();
		t_power_on();
		t_active();
		t_sleep();
		t_restart();
		t_power_off(1'b0, 1'b0);
		t_power_on();
		t_power_off(1'b1, 1'b1);
		t_power_on();
		t_power_off(1'b1, 1'b0);
		final_report();
	end
endmodule
